// ---- dv/ppis_properties.sv ----
// Purpose: bus and flag timing checks
// Assumes: one access at a time
// Notes: bound to ppis_top
`timescale 1ns/1ps
module ppis_properties (
  // watched ports
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [2:0] scheduled_pulse_unit_done_i,
  input wire logic [1:0] event_capture_unit_capture_i,
  input wire logic pin_unit_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic rd_flags;
  logic any_evt;
  assign rd_flags = avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h0528;
  assign any_evt = |{scheduled_pulse_unit_done_i, event_capture_unit_capture_i};
  chk_ack_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("ack too long");
  chk_ack_bound: assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("ack late");
  chk_ack_cause: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("ack without access");
  chk_irq_rise: assert property ($rose(pin_unit_irq_o) |-> $past(any_evt, 2))
    else $error("irq rose without event");
  chk_irq_fall: assert property ($fell(pin_unit_irq_o) |-> $past(avs_write_i, 2))
    else $error("irq fell without write");
  chk_irq_holds: assert property (pin_unit_irq_o && !avs_write_i |=> pin_unit_irq_o)
    else $error("irq dropped");
  chk_resv_zero: assert property (rd_flags |-> (avs_readdata_o & 32'hFFF8_FFFC) == 0)
    else $error("reserved bit set");
  chk_irq_or: assert property (rd_flags |-> (|avs_readdata_o) == pin_unit_irq_o)
    else $error("irq not flag or");
endmodule
bind ppis_top ppis_properties i_chk (.*);

// ---- dv/ppis_top_test.sv ----
// Purpose: register level test of ppis_top
// Assumes: byte enables all set, except one flags write with byte 0 only
// Notes: events pulsed for one cycle
`timescale 1ns/1ps
module ppis_top_test;
  logic sys_clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic avs_waitrequest_o, pin_unit_irq_o;
  logic [11:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, rdat;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [2:0] scheduled_pulse_unit_done_i = 0;
  logic [1:0] event_capture_unit_capture_i = 0;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  ppis_top i_dut (.*);
  always #25 sys_clk_i = ~sys_clk_i;
  task finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(n, e, rdat);
  endtask
  task pulse(input logic [2:0] p, input logic [1:0] c);
    @(posedge sys_clk_i);
    scheduled_pulse_unit_done_i <= p;
    event_capture_unit_capture_i <= c;
    @(posedge sys_clk_i);
    scheduled_pulse_unit_done_i <= 0;
    event_capture_unit_capture_i <= 0;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 0;
    rd("flags", 12'h0528, 32'h0000_0000);
    acc(1, 12'h0600, 32'h0000_0007);
    acc(1, 12'h052C, 32'h0000_0020);
    acc(1, 12'h0520, 32'h0000_0100);
    acc(1, 12'h052C, 32'h0000_0020);
    rd("index", 12'h0520, 32'h0000_0100);
    rd("ctrl", 12'h052C, 32'h0000_0020);
    rd("notify", 12'h0600, 32'h0000_0007);
    pulse(3'h7, 2'h3);
    rd("flags", 12'h0528, 32'h0007_0003);
    chk("irq", 32'h0000_0001, {31'h0, pin_unit_irq_o});
    acc(1, 12'h0528, 32'h0001_0001);
    rd("flags", 12'h0528, 32'h0006_0002);
    avs_byteenable_i <= 4'h1;
    acc(1, 12'h0528, 32'hFFFF_FFFF);
    avs_byteenable_i <= 4'hF;
    rd("flags", 12'h0528, 32'h0006_0000);
    acc(1, 12'h0528, 32'hFFFF_FFFF);
    rd("flags", 12'h0528, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {31'h0, pin_unit_irq_o});
    acc(1, 12'h0600, 32'h0000_0002);
    acc(1, 12'h052C, 32'h0000_0000);
    pulse(3'h7, 2'h3);
    rd("flags", 12'h0528, 32'h0002_0001);
    rd("unmapped", 12'h0700, 32'h0000_0000);
    finish_test;
  end
endmodule

// ---- include/ppis_cfg.svh ----
// Purpose: offsets, field positions and reset values of the pin time unit irq block
// Assumes: avalon-mm word addressing by byte address, 32-bit data
// Notes: how it works listed below
// How it works
// [RL1] one 32-bit flag register at 0x0528
// [RL2] global pin irq bit is OR of flags
// [RL3] pulse unit flags bits 18:16, write clears
// [RL4] pulse flag sets only with notify enable
// [RL5] capture unit flags bits 1:0, write clears
// [RL6] capture flag sets only with irq enable
// [RL7] port egress timestamp irqs excluded here
// [RL8] pulse unit done plus notify raises irq
// [RL9] capture enable is control bit 5, indexed
// [RL10] reserved bits read zero, writes ignored
`ifndef PPIS_CFG_SVH
`define PPIS_CFG_SVH
`define PPIS_ADDR_W 12
`define PPIS_OFS_INDEX 12'h0520
`define PPIS_OFS_FLAGS 12'h0528
`define PPIS_OFS_CTRL 12'h052C
`define PPIS_OFS_NOTIFY 12'h0600
`define PPIS_FLD_PULSE_LO 16
`define PPIS_FLD_CAP_LO 0
`define PPIS_FLD_CAP_PTR 8
`define PPIS_FLD_CAP_IRQ_EN 5
`define PPIS_RST_PULSE 3'h0
`define PPIS_RST_CAP 2'h0
`define PPIS_N_PULSE 3
`define PPIS_N_CAP 2
`endif

// ---- include/ppis_pkg.sv ----
// Purpose: shared types of the pin time unit irq block
// Assumes: nothing
// Notes: bus handshake phases
package ppis_pkg;
  typedef enum logic [1:0] {
    ppis_idle,
    ppis_answer
  } ppis_bus_state_t;
endpackage

// ---- logic/ppis_flag.sv ----
// Purpose: one sticky event flag with enable gating and write clear
// Assumes: event is a one-cycle pulse on sys_clk_i
// Notes: a set in the clear cycle wins
`timescale 1ns/1ps
module ppis_flag (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // event side
  input wire logic event_i,
  input wire logic enable_i,
  input wire logic clear_i,
  // state
  output logic flag_o
);
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flag_o <= 1'b0;
    end else if (event_i && enable_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

// ---- logic/ppis_top.sv ----
// Purpose: irq status collector for pulse and capture units
// Assumes: unit events are one-cycle pulses on sys_clk_i
// Notes: answers each access one cycle after it is raised
// Notes: writes act at the take edge, one edge before waitrequest is seen low
// Notes: unit events come from logic on sys_clk_i, so they pass no synchroniser
`timescale 1ns/1ps
`include "ppis_cfg.svh"
module ppis_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // unit events
  input wire logic [2:0] scheduled_pulse_unit_done_i,
  input wire logic [1:0] event_capture_unit_capture_i,
  // global status bit
  output logic pin_unit_irq_o
);
  // unit counts
  localparam int N_PULSE = `PPIS_N_PULSE;
  localparam int N_CAP = `PPIS_N_CAP;

  // bus handshake
  ppis_pkg::ppis_bus_state_t state;
  logic bus_idle;
  logic wr_take;
  logic rd_take;
  logic [31:0] next_readdata;

  // address decode
  logic hit_index;
  logic hit_flags;
  logic hit_ctrl;
  logic hit_notify;

  // unit enables and index
  logic [2:0] completion_notify_enable;
  logic [1:0] capture_irq_enable;
  logic cap_ptr;

  // flags and their clears
  logic [2:0] pulse_flags;
  logic [1:0] cap_flags;
  logic [2:0] pulse_clear;
  logic [1:0] cap_clear;

  // address match for one register offset
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // place unit flags in the status word, reserved bits zero
  function automatic logic [31:0] pack_flags(input logic [2:0] pulse, input logic [1:0] cap);
    pack_flags = 32'h0000_0000;
    pack_flags[`PPIS_FLD_PULSE_LO +: 3] = pulse;
    pack_flags[`PPIS_FLD_CAP_LO +: 2] = cap;
  endfunction

  assign hit_index = reg_hit(avs_address_i, `PPIS_OFS_INDEX);
  assign hit_flags = reg_hit(avs_address_i, `PPIS_OFS_FLAGS);
  assign hit_ctrl = reg_hit(avs_address_i, `PPIS_OFS_CTRL);
  assign hit_notify = reg_hit(avs_address_i, `PPIS_OFS_NOTIFY);

  // requests are taken only while idle
  assign bus_idle = (state == ppis_pkg::ppis_idle);
  assign wr_take = avs_write_i && bus_idle;
  assign rd_take = avs_read_i && bus_idle;

  // handshake phase
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= ppis_pkg::ppis_idle;
    end else begin
      case (state)
        ppis_pkg::ppis_idle: begin
          if (avs_read_i || avs_write_i) begin
            state <= ppis_pkg::ppis_answer;
          end
        end
        ppis_pkg::ppis_answer: begin
          state <= ppis_pkg::ppis_idle;
        end
        default: begin
          state <= ppis_pkg::ppis_idle;
        end
      endcase
    end
  end

  // waitrequest low for one cycle per access
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (bus_idle && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // [RL9] capture unit pointer
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cap_ptr <= 1'b0;
    end else if (wr_take && hit_index && avs_byteenable_i[1]) begin
      cap_ptr <= avs_writedata_i[`PPIS_FLD_CAP_PTR];
    end
  end

  // [RL9] enable of the pointed unit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      capture_irq_enable <= `PPIS_RST_CAP;
    end else if (wr_take && hit_ctrl && avs_byteenable_i[0]) begin
      capture_irq_enable[cap_ptr] <= avs_writedata_i[`PPIS_FLD_CAP_IRQ_EN];
    end
  end

  // [RL4] per-unit notify enables
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      completion_notify_enable <= `PPIS_RST_PULSE;
    end else if (wr_take && hit_notify && avs_byteenable_i[0]) begin
      completion_notify_enable <= avs_writedata_i[2:0];
    end
  end

  // [RL10] reserved write bits dropped
  // [RL3] write one clears pulse flag
  always_comb begin
    pulse_clear = 3'h0;
    if (wr_take && hit_flags && avs_byteenable_i[2]) begin
      pulse_clear = avs_writedata_i[`PPIS_FLD_PULSE_LO +: 3];
    end
  end

  // [RL5] write one clears capture flag
  always_comb begin
    cap_clear = 2'h0;
    if (wr_take && hit_flags && avs_byteenable_i[0]) begin
      cap_clear = avs_writedata_i[`PPIS_FLD_CAP_LO +: 2];
    end
  end

  // [RL8] done pulse with notify raises flag
  // one flag per unit, set wins over clear
  for (genvar i = 0; i < N_PULSE; i++) begin : g_pulse
    ppis_flag u_flag (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .event_i(scheduled_pulse_unit_done_i[i]),
      .enable_i(completion_notify_enable[i]),
      .clear_i(pulse_clear[i]),
      .flag_o(pulse_flags[i])
    );
  end

  // [RL6] capture flag gated by enable
  // [RL7] pin captures only, no egress
  for (genvar j = 0; j < N_CAP; j++) begin : g_cap
    ppis_flag u_flag (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .event_i(event_capture_unit_capture_i[j]),
      .enable_i(capture_irq_enable[j]),
      .clear_i(cap_clear[j]),
      .flag_o(cap_flags[j])
    );
  end

  // [RL1] register read mux
  // [RL10] reserved bits read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address_i)
      `PPIS_OFS_FLAGS: begin
        next_readdata = pack_flags(pulse_flags, cap_flags);
      end
      `PPIS_OFS_INDEX: begin
        next_readdata[`PPIS_FLD_CAP_PTR] = cap_ptr;
      end
      `PPIS_OFS_CTRL: begin
        next_readdata[`PPIS_FLD_CAP_IRQ_EN] = capture_irq_enable[cap_ptr];
      end
      `PPIS_OFS_NOTIFY: begin
        next_readdata[2:0] = completion_notify_enable;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // [RL2] OR of all flags
  // registered, so it trails the flags by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_unit_irq_o <= 1'b0;
    end else begin
      pin_unit_irq_o <= |pack_flags(pulse_flags, cap_flags);
    end
  end
endmodule
